// [hdl/monitor_execute_frame_handler.v]
// monitor-execution request parser and reply frame builder
//
// Behaviour
// - execute reads values bound to named slot
// - lowercase request check: low byte sum ENQ..EOT
// - lowercase error reply check: sum NAK..ETX
// - individual format reply carries block count
// - continuous format reply omits block count
// - failure reply: NAK, fields, 4-char code
// - ten slots, re-registration replaces contents
`timescale 1ns/1ps
`default_nettype none
`include "monitor_exec_regs.vh"

module monitor_execute_frame_handler #(
   parameter SLOTS = `MX_SLOTS
) (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire       rx_valid_i,
   input  wire [7:0] rx_byte_i,
   input  wire [7:0] station_i,
   input  wire       reg_wr_i,
   input  wire [3:0] reg_slot_i,
   input  wire       reg_fmt_i,
   input  wire [7:0] reg_blocks_i,
   input  wire [7:0] reg_ndata_i,
   output reg        val_req_o,
   output reg  [3:0] val_slot_o,
   output reg  [7:0] val_blk_o,
   output reg  [7:0] val_idx_o,
   input  wire       val_ack_i,
   input  wire [7:0] val_data_i,
   output reg        tx_valid_o,
   output reg  [7:0] tx_byte_o,
   input  wire       tx_ready_i
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // ascii hex digit to value; bit 4 flags a non-hex character
   function [4:0] hexval;
      input [7:0] c;
      begin
         if (c >= 8'h30 && c <= 8'h39) hexval = {1'b0, c[3:0]};
         else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
            hexval = {1'b0, c[3:0] + 4'h9};
         else hexval = 5'h10;
      end
   endfunction

   // nibble to upper-case ascii hex digit
   function [7:0] to_hex;
      input [3:0] n;
      begin
         to_hex = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
      end
   endfunction

   // ------------------------------------------------------------
   // registration table
   // ------------------------------------------------------------
   reg  [SLOTS-1:0]        used_q;
   reg  [3:0]              slot_q;
   wire [`MX_REC_W-1:0]    rec;
   wire                    fmt    = rec[`MX_REC_FMT];
   wire [7:0]              blocks = rec[15:8];
   wire [7:0]              ndata  = rec[7:0];
   wire                    reg_ok = (reg_slot_i < SLOTS);

   slot_table_mem #(
      .DEPTH (SLOTS),
      .AW    (`MX_SLOT_AW),
      .DW    (`MX_REC_W)
   ) u_table (
      .clk_i     (clk_i),
      .wr_en_i   (reg_wr_i & reg_ok),
      .wr_addr_i (reg_slot_i),
      .wr_data_i ({reg_fmt_i, reg_blocks_i, reg_ndata_i}),
      .rd_addr_i (slot_q),
      .rd_data_o (rec)
   );

   // a slot stays in use once registered; a new record overwrites the old
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         used_q <= {SLOTS{1'b0}};
      end else if (reg_wr_i && reg_ok) begin
         used_q[reg_slot_i] <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // request parser
   // ------------------------------------------------------------
   reg  [3:0]  p_q;
   reg  [7:0]  rsum_q;
   reg  [15:0] st_q;
   reg  [15:0] rn_q;
   reg  [15:0] bc_q;
   reg  [7:0]  cmd_q;
   reg         lower_q;
   reg         go_q;
   reg         nak_q;
   reg  [15:0] err_q;
   reg  [4:0]  t_q;
   wire        tx_busy = (t_q != `MX_T_IDLE) | go_q;
   wire [4:0]  st_hi   = hexval(st_q[15:8]);
   wire [4:0]  st_lo   = hexval(st_q[7:0]);
   wire [4:0]  bc_hi   = hexval(bc_q[15:8]);
   wire [4:0]  bc_lo   = hexval(bc_q[7:0]);
   wire        addr_ok = !st_hi[4] && !st_lo[4] && ({st_hi[3:0], st_lo[3:0]} == station_i);
   wire        bcc_ok  = !lower_q ||
                         (!bc_hi[4] && !bc_lo[4] && ({bc_hi[3:0], bc_lo[3:0]} == rsum_q));
   wire        rn_ok   = (rn_q[15:8] == `MX_ASCII_ZERO) &&
                         (rn_q[7:0] >= `MX_ASCII_ZERO) && (rn_q[7:0] <= `MX_ASCII_NINE);

   // bytes arriving while a reply is in progress are dropped, ENQ included; otherwise an ENQ restarts
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p_q     <= `MX_P_IDLE;
         rsum_q  <= 8'h00;
         st_q    <= 16'h0000;
         rn_q    <= 16'h0000;
         bc_q    <= 16'h0000;
         cmd_q   <= 8'h00;
         lower_q <= 1'b0;
         go_q    <= 1'b0;
         nak_q   <= 1'b0;
         err_q   <= 16'h0000;
         slot_q  <= 4'h0;
      end else begin
         go_q <= 1'b0;
         if (p_q == `MX_P_DONE) begin
            p_q <= `MX_P_IDLE;
            // frames for another station are silently ignored
            if (addr_ok) begin
               go_q   <= 1'b1;
               slot_q <= rn_q[3:0];
               nak_q  <= !bcc_ok || !rn_ok || !used_q[rn_q[3:0]];
               if (!bcc_ok) err_q <= `MX_ERR_BCC;
               else if (!rn_ok) err_q <= `MX_ERR_RANGE;
               else err_q <= `MX_ERR_NOREG;
            end
         end else if (rx_valid_i && !tx_busy) begin
            if (rx_byte_i == `MX_ENQ) begin
               p_q    <= `MX_P_ST0;
               rsum_q <= `MX_ENQ;
            end else begin
               if (p_q < `MX_P_BC0) rsum_q <= rsum_q + rx_byte_i;
               case (p_q)
                  `MX_P_ST0: begin
                     st_q[15:8] <= rx_byte_i;
                     p_q        <= `MX_P_ST1;
                  end
                  `MX_P_ST1: begin
                     st_q[7:0] <= rx_byte_i;
                     p_q       <= `MX_P_CMD;
                  end
                  `MX_P_CMD: begin
                     // any other command belongs to another handler
                     cmd_q   <= rx_byte_i;
                     lower_q <= (rx_byte_i == `MX_CMD_LOWER);
                     p_q     <= (rx_byte_i == `MX_CMD_LOWER || rx_byte_i == `MX_CMD_UPPER) ?
                                `MX_P_RN0 : `MX_P_IDLE;
                  end
                  `MX_P_RN0: begin
                     rn_q[15:8] <= rx_byte_i;
                     p_q        <= `MX_P_RN1;
                  end
                  `MX_P_RN1: begin
                     rn_q[7:0] <= rx_byte_i;
                     p_q       <= `MX_P_EOT;
                  end
                  `MX_P_EOT: begin
                     if (rx_byte_i != `MX_EOT) p_q <= `MX_P_IDLE;
                     else if (lower_q) p_q <= `MX_P_BC0;
                     else p_q <= `MX_P_DONE;
                  end
                  `MX_P_BC0: begin
                     bc_q[15:8] <= rx_byte_i;
                     p_q        <= `MX_P_BC1;
                  end
                  `MX_P_BC1: begin
                     bc_q[7:0] <= rx_byte_i;
                     p_q       <= `MX_P_DONE;
                  end
                  default: p_q <= `MX_P_IDLE;
               endcase
            end
         end
      end
   end

   // ------------------------------------------------------------
   // reply builder: next character and next state
   // ------------------------------------------------------------
   reg  [7:0] tsum_q;
   reg  [7:0] blk_q;
   reg  [7:0] idx_q;
   reg  [7:0] dat_q;
   reg  [1:0] ecnt_q;
   reg  [7:0] nb;
   reg  [4:0] nx;
   reg        emit;
   wire [7:0] fsum    = tsum_q + `MX_ETX;
   wire [7:0] blk_nx  = blk_q + 8'h01;
   wire [4:0] blk_end = (fmt == `MX_FMT_INDIV && blk_nx < blocks) ? `MX_T_ND0 : `MX_T_ETX;
   wire [3:0] err_nib = err_q[{~ecnt_q, 2'b00} +: 4];

   always @* begin
      nb   = 8'h00;
      nx   = t_q;
      emit = 1'b1;
      case (t_q)
         `MX_T_HDR: begin
            nb = nak_q ? `MX_NAK : `MX_ACK;
            nx = `MX_T_ST0;
         end
         `MX_T_ST0: begin nb = st_q[15:8]; nx = `MX_T_ST1; end
         `MX_T_ST1: begin nb = st_q[7:0]; nx = `MX_T_CMD; end
         `MX_T_CMD: begin nb = cmd_q; nx = `MX_T_RN0; end
         `MX_T_RN0: begin nb = rn_q[15:8]; nx = `MX_T_RN1; end
         `MX_T_RN1: begin
            nb = rn_q[7:0];
            if (nak_q) nx = `MX_T_ERR;
            else if (fmt == `MX_FMT_CONT) nx = `MX_T_ND0;
            else nx = `MX_T_NB0;
         end
         `MX_T_NB0: begin nb = to_hex(blocks[7:4]); nx = `MX_T_NB1; end
         `MX_T_NB1: begin
            nb = to_hex(blocks[3:0]);
            nx = (blocks == 8'h00) ? `MX_T_ETX : `MX_T_ND0;
         end
         `MX_T_ND0: begin nb = to_hex(ndata[7:4]); nx = `MX_T_ND1; end
         `MX_T_ND1: begin
            nb = to_hex(ndata[3:0]);
            nx = (ndata == 8'h00) ? blk_end : `MX_T_FETCH;
         end
         `MX_T_DH: begin nb = to_hex(dat_q[7:4]); nx = `MX_T_DL; end
         `MX_T_DL: begin
            nb = to_hex(dat_q[3:0]);
            nx = (idx_q + 8'h01 < ndata) ? `MX_T_FETCH : blk_end;
         end
         `MX_T_ERR: begin
            nb = to_hex(err_nib);
            nx = (ecnt_q == 2'h3) ? `MX_T_ETX : `MX_T_ERR;
         end
         `MX_T_ETX: begin
            nb = `MX_ETX;
            nx = lower_q ? `MX_T_BC0 : `MX_T_IDLE;
         end
         `MX_T_BC0: begin nb = to_hex(fsum[7:4]); nx = `MX_T_BC1; end
         `MX_T_BC1: begin nb = to_hex(fsum[3:0]); nx = `MX_T_IDLE; end
         default: emit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // reply builder: byte handshake, value fetch and counters
   // ------------------------------------------------------------
   // a character is held on tx_byte_o until tx_ready_i takes it
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         t_q        <= `MX_T_IDLE;
         tsum_q     <= 8'h00;
         blk_q      <= 8'h00;
         idx_q      <= 8'h00;
         dat_q      <= 8'h00;
         ecnt_q     <= 2'h0;
         tx_valid_o <= 1'b0;
         tx_byte_o  <= 8'h00;
         val_req_o  <= 1'b0;
         val_slot_o <= 4'h0;
         val_blk_o  <= 8'h00;
         val_idx_o  <= 8'h00;
      end else begin
         if (tx_valid_o && tx_ready_i) tx_valid_o <= 1'b0;
         case (t_q)
            `MX_T_IDLE: if (go_q) t_q <= `MX_T_WAIT;
            // one cycle for the table read to settle on slot_q
            `MX_T_WAIT: t_q <= `MX_T_HDR;
            `MX_T_FETCH: begin
               if (!val_req_o) begin
                  val_req_o  <= 1'b1;
                  val_slot_o <= slot_q;
                  val_blk_o  <= blk_q;
                  val_idx_o  <= idx_q;
               end else if (val_ack_i) begin
                  val_req_o <= 1'b0;
                  dat_q     <= val_data_i;
                  t_q       <= `MX_T_DH;
               end
            end
            default: begin
               if (emit && (!tx_valid_o || tx_ready_i)) begin
                  tx_valid_o <= 1'b1;
                  tx_byte_o  <= nb;
                  t_q        <= nx;
                  // running sum covers header through tail, restarted per reply
                  if (t_q == `MX_T_HDR) tsum_q <= nb;
                  else if (t_q < `MX_T_ETX) tsum_q <= tsum_q + nb;
                  if (t_q == `MX_T_HDR) begin
                     blk_q  <= 8'h00;
                     ecnt_q <= 2'h0;
                  end
                  if (t_q == `MX_T_ERR) ecnt_q <= ecnt_q + 2'h1;
                  if (t_q == `MX_T_ND1) idx_q <= 8'h00;
                  if (t_q == `MX_T_DL) idx_q <= idx_q + 8'h01;
                  if ((t_q == `MX_T_DL || t_q == `MX_T_ND1) && nx == `MX_T_ND0)
                     blk_q <= blk_nx;
               end
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// [pkg/monitor_exec_regs.vh]
// character codes, error codes and state encodings of the monitor-execution frame handler
`ifndef MONITOR_EXEC_REGS_VH
`define MONITOR_EXEC_REGS_VH

// ------------------------------------------------------------
// frame control characters, command characters and ascii digit bounds
// ------------------------------------------------------------
`define MX_ENQ        8'h05
`define MX_ACK        8'h06
`define MX_NAK        8'h15
`define MX_EOT        8'h04
`define MX_ETX        8'h03
`define MX_CMD_UPPER  8'h59
`define MX_CMD_LOWER  8'h79
`define MX_ASCII_ZERO 8'h30
`define MX_ASCII_NINE 8'h39

// ------------------------------------------------------------
// error codes carried in a refusal reply
// ------------------------------------------------------------
`define MX_ERR_BCC    16'h0B01
`define MX_ERR_RANGE  16'h0B02
`define MX_ERR_NOREG  16'h0B03

// ------------------------------------------------------------
// slot table geometry and record layout {fmt, blocks, ndata}
// ------------------------------------------------------------
`define MX_SLOTS      10
`define MX_SLOT_AW    4
`define MX_REC_W      17
`define MX_REC_FMT    16
`define MX_FMT_INDIV  1'b0
`define MX_FMT_CONT   1'b1

// ------------------------------------------------------------
// receive parser states
// ------------------------------------------------------------
`define MX_P_IDLE     4'h0
`define MX_P_ST0      4'h1
`define MX_P_ST1      4'h2
`define MX_P_CMD      4'h3
`define MX_P_RN0      4'h4
`define MX_P_RN1      4'h5
`define MX_P_EOT      4'h6
`define MX_P_BC0      4'h7
`define MX_P_BC1      4'h8
`define MX_P_DONE     4'h9

// ------------------------------------------------------------
// transmit states
// ------------------------------------------------------------
`define MX_T_IDLE     5'h00
`define MX_T_WAIT     5'h01
`define MX_T_HDR      5'h02
`define MX_T_ST0      5'h03
`define MX_T_ST1      5'h04
`define MX_T_CMD      5'h05
`define MX_T_RN0      5'h06
`define MX_T_RN1      5'h07
`define MX_T_NB0      5'h08
`define MX_T_NB1      5'h09
`define MX_T_ND0      5'h0A
`define MX_T_ND1      5'h0B
`define MX_T_FETCH    5'h0C
`define MX_T_DH       5'h0D
`define MX_T_DL       5'h0E
`define MX_T_ERR      5'h0F
`define MX_T_ETX      5'h10
`define MX_T_BC0      5'h11
`define MX_T_BC1      5'h12

`endif

// [hdl/slot_table_mem.v]
// small memory holding one registration record per slot, registered read
`timescale 1ns/1ps
`default_nettype none

module slot_table_mem #(
   parameter DEPTH = 10,
   parameter AW    = 4,
   parameter DW    = 17
) (
   input  wire          clk_i,
   input  wire          wr_en_i,
   input  wire [AW-1:0] wr_addr_i,
   input  wire [DW-1:0] wr_data_i,
   input  wire [AW-1:0] rd_addr_i,
   output reg  [DW-1:0] rd_data_o
);

   reg [DW-1:0] mem [0:DEPTH-1];

   // write replaces any earlier record; read data leave a flip-flop
   always @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end

endmodule
`default_nettype wire

// [tb/frame_handler_monitor.sv]
// concurrent checks on the ports of the monitor-execution frame handler
`timescale 1ns/1ps
`default_nettype none
`include "monitor_exec_regs.vh"
module frame_handler_monitor #(
   parameter SLOTS = 10
) (
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   input wire logic       rx_valid_i,
   input wire logic [7:0] rx_byte_i,
   input wire logic [7:0] station_i,
   input wire logic       reg_wr_i,
   input wire logic [3:0] reg_slot_i,
   input wire logic       reg_fmt_i,
   input wire logic [7:0] reg_blocks_i,
   input wire logic [7:0] reg_ndata_i,
   input wire logic       val_req_o,
   input wire logic [3:0] val_slot_o,
   input wire logic [7:0] val_blk_o,
   input wire logic [7:0] val_idx_o,
   input wire logic       val_ack_i,
   input wire logic [7:0] val_data_i,
   input wire logic       tx_valid_o,
   input wire logic [7:0] tx_byte_o,
   input wire logic       tx_ready_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [7:0] data_q;
   // -------------------------------------------------
   // fetch and reply steps
   // -------------------------------------------------
   sequence fetch_wait; val_req_o && !val_ack_i; endsequence
   sequence fetch_done; val_req_o && val_ack_i; endsequence
   sequence tx_stall; tx_valid_o && !tx_ready_i; endsequence
   // a rise not caused by a fetch must be a new reply frame
   sequence frame_start; $rose(tx_valid_o) && !$past(val_ack_i) && !$past(val_ack_i, 2); endsequence
   // last fetched byte, so the hex char that follows can be judged
   always_ff @(posedge clk_i) begin
      if (val_req_o && val_ack_i) data_q <= val_data_i;
   end
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction
   AST_REQ_HOLD: assert property (fetch_wait |=> val_req_o && $stable({val_slot_o, val_blk_o, val_idx_o}))
      else $error("value request changed before ack");
   AST_REQ_DROP: assert property (fetch_done |=> !val_req_o)
      else $error("value request kept after ack");
   // a slow transmitter may still hold the previous char for up to four cycles
   AST_DATA_HEX: assert property (fetch_done |-> ##[2:6] (tx_valid_o && tx_byte_o == hx(data_q[7:4])))
      else $error("fetched byte not sent as high hex char");
   // the char before a fetch may still be waiting; no new one may appear meanwhile
   AST_FETCH_QUIET: assert property (val_req_o |=> !$rose(tx_valid_o))
      else $error("reply char offered while fetching");
   AST_SLOT_RANGE: assert property (val_req_o |-> val_slot_o < SLOTS)
      else $error("value request for slot outside table");
   AST_TX_HOLD: assert property (tx_stall |=> tx_valid_o && $stable(tx_byte_o))
      else $error("reply char changed before taken");
   AST_HDR: assert property (frame_start |-> tx_byte_o == `MX_ACK || tx_byte_o == `MX_NAK)
      else $error("reply frame starts with wrong header");
   // last char taken at edge 0, header loaded at edge 4, its rise seen at edge 5
   AST_LATENCY: assert property (frame_start |-> $past(rx_valid_i, 5))
      else $error("reply header not loaded four cycles after last request char");
endmodule
`default_nettype wire

// [tb/host_model.sv]
// host-side model: sends request characters and takes reply characters
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic       clk_i,
   input wire logic       slow_i,
   input wire logic       reply_valid_i,
   input wire logic [7:0] reply_byte_i,
   output var logic       reply_ready_o,
   output var logic       req_valid_o,
   output var logic [7:0] req_byte_o
);
   logic [7:0] got[$];
   logic [1:0] cnt_q = 2'h0;
   initial begin
      reply_ready_o = 1'b1;
      req_valid_o = 1'b0;
      req_byte_o = 8'h00;
   end
   // takes a char on ready; a slow host stalls three cycles of four
   always @(posedge clk_i) begin
      if (reply_valid_i && reply_ready_o) got.push_back(reply_byte_i);
      cnt_q <= cnt_q + 2'h1;
      #1;
      reply_ready_o = !slow_i || cnt_q == 2'h0;
   end
   // one char per cycle; idle line shows the inverse so stale data never matches
   task automatic send(input logic [7:0] b[$]);
      foreach (b[k]) begin
         @(posedge clk_i);
         #1;
         req_valid_o = 1'b1;
         req_byte_o = b[k];
      end
      @(posedge clk_i);
      #1;
      req_valid_o = 1'b0;
      req_byte_o = ~req_byte_o;
   endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the monitor-execution frame handler
`timescale 1ns/1ps
`default_nettype none
`include "monitor_exec_regs.vh"
module tb;
   localparam logic [7:0] STN = 8'h1A;
   logic        clk_i, rst_n_i, reg_wr_i, reg_fmt_i, slow;
   logic        val_ack_i = 1'b0;
   logic [7:0]  val_data_i = 8'h00;
   logic [3:0]  reg_slot_i;
   logic [7:0]  reg_blocks_i, reg_ndata_i, rx_byte_i, tx_byte_o;
   logic [7:0]  val_blk_o, val_idx_o;
   logic [3:0]  val_slot_o;
   logic        rx_valid_i, tx_valid_o, tx_ready_i, val_req_o;
   logic [31:0] seed = 32'h0000AC5B;
   logic [31:0] r;
   logic [16:0] tbl[10];
   logic        used[10] = '{default: 1'b0};
   logic [7:0]  exp[$];
   int          bad_count = 0;
   int          tests_run = 0;
   monitor_execute_frame_handler #(.SLOTS(10)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .station_i(STN), .reg_wr_i(reg_wr_i),
      .reg_slot_i(reg_slot_i), .reg_fmt_i(reg_fmt_i), .reg_blocks_i(reg_blocks_i),
      .reg_ndata_i(reg_ndata_i), .val_req_o(val_req_o), .val_slot_o(val_slot_o),
      .val_blk_o(val_blk_o), .val_idx_o(val_idx_o), .val_ack_i(val_ack_i),
      .val_data_i(val_data_i), .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o),
      .tx_ready_i(tx_ready_i));
   host_model host (.clk_i(clk_i), .slow_i(slow), .reply_valid_i(tx_valid_o),
      .reply_byte_i(tx_byte_o), .reply_ready_o(tx_ready_i), .req_valid_o(rx_valid_i),
      .req_byte_o(rx_byte_i));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction
   // value bound to a slot position, distinct per slot, block and index
   function automatic logic [7:0] vof(input logic [3:0] s, input logic [7:0] b, input logic [7:0] i);
      return ({s, 4'h0} ^ (b * 8'h07)) + i * 8'h35 + 8'h5A;
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic push2(input logic [7:0] b);
      exp.push_back(hx(b[7:4]));
      exp.push_back(hx(b[3:0]));
   endtask
   task automatic regw(input logic [3:0] sl, input logic fm, input logic [7:0] nb,
                       input logic [7:0] nd);
      @(posedge clk_i);
      #1;
      reg_wr_i = 1'b1;
      reg_slot_i = sl;
      reg_fmt_i = fm;
      reg_blocks_i = nb;
      reg_ndata_i = nd;
      @(posedge clk_i);
      #1;
      reg_wr_i = 1'b0;
      tbl[sl] = {fm, nb, nd};
      used[sl] = 1'b1;
   endtask
   // sends one request and compares the whole reply against the expected frame
   task automatic run(input logic [7:0] cmd, input logic [7:0] r0, input logic [7:0] r1,
                      input logic bad, input logic [7:0] st);
      logic [7:0]  f[$];
      logic [7:0]  s;
      logic [15:0] code;
      logic [3:0]  sl;
      int          n;
      f = {`MX_ENQ, hx(st[7:4]), hx(st[3:0]), cmd, r0, r1, `MX_EOT};
      s = 8'h00;
      foreach (f[k]) s += f[k];
      s = s + {7'h0, bad};
      if (cmd == `MX_CMD_LOWER) f = {f, hx(s[7:4]), hx(s[3:0])};
      sl = r1[3:0];
      code = bad ? `MX_ERR_BCC : (r0 != 8'h30 || r1 < 8'h30 || r1 > 8'h39) ? `MX_ERR_RANGE
           : !used[sl] ? `MX_ERR_NOREG : 16'h0000;
      exp = {};
      host.got = {};
      // other stations and other command chars get no reply at all
      if (st == STN && (cmd == `MX_CMD_LOWER || cmd == `MX_CMD_UPPER)) begin
         exp = {(code != 16'h0) ? `MX_NAK : `MX_ACK, hx(st[7:4]), hx(st[3:0]), cmd, r0, r1};
         if (code != 16'h0) begin
            push2(code[15:8]);
            push2(code[7:0]);
         end else begin
            if (!tbl[sl][16]) push2(tbl[sl][15:8]);
            for (int b = 0; b < (tbl[sl][16] ? 1 : tbl[sl][15:8]); b++) begin
               push2(tbl[sl][7:0]);
               for (int i = 0; i < tbl[sl][7:0]; i++) push2(vof(sl, 8'(b), 8'(i)));
            end
         end
         exp.push_back(`MX_ETX);
         s = 8'h00;
         foreach (exp[k]) s += exp[k];
         if (cmd == `MX_CMD_LOWER) push2(s);
      end
      host.send(f);
      n = 0;
      while (host.got.size() < exp.size() && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      repeat (12) @(posedge clk_i);
      check(8'(host.got.size()), 8'(exp.size()));
      foreach (exp[k]) if (k < host.got.size()) check(host.got[k], exp[k]);
   endtask
   // value source answers after a random delay, inverse data when idle
   always @(posedge clk_i) begin
      #1;
      void'(rnd());
      val_ack_i = val_req_o === 1'b1 && !val_ack_i && seed[1];
      val_data_i = val_ack_i ? vof(val_slot_o, val_blk_o, val_idx_o) : ~val_data_i;
   end
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // watchdog sized well beyond the scenarios below
   initial begin
      #400000;
      bad_count++;
      finish_test();
   end
   initial begin
      {rst_n_i, reg_wr_i, reg_fmt_i, slow, reg_slot_i} = 0;
      {reg_blocks_i, reg_ndata_i} = 0;
      repeat (8) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      regw(4'h1, 1'b0, 8'h02, 8'h02);
      run(`MX_CMD_LOWER, 8'h30, 8'h31, 1'b0, STN);
      regw(4'h9, 1'b1, 8'h00, 8'h03);
      slow = 1'b1;
      run(`MX_CMD_UPPER, 8'h30, 8'h39, 1'b0, STN);
      regw(4'h1, 1'b1, 8'h05, 8'h01);
      run(`MX_CMD_UPPER, 8'h30, 8'h31, 1'b0, STN);
      regw(4'h2, 1'b0, 8'h00, 8'h04);
      run(`MX_CMD_LOWER, 8'h30, 8'h32, 1'b0, STN);
      run(`MX_CMD_LOWER, 8'h30, 8'h35, 1'b0, STN);
      run(`MX_CMD_UPPER, 8'h30, 8'h41, 1'b0, STN);
      run(`MX_CMD_LOWER, 8'h31, 8'h30, 1'b0, STN);
      run(`MX_CMD_LOWER, 8'h30, 8'h31, 1'b1, STN);
      run(`MX_CMD_UPPER, 8'h30, 8'h31, 1'b0, 8'h2B);
      run(8'h58, 8'h30, 8'h31, 1'b0, STN);
      for (int k = 0; k < 14; k++) begin
         r = rnd();
         regw(4'(r[7:0] % 10), r[8], {6'h0, r[10:9]}, {6'h0, r[12:11]});
         slow = r[13];
         run(r[14] ? `MX_CMD_LOWER : `MX_CMD_UPPER, 8'h30, 8'h30 + 8'(r[7:0] % 10), 1'b0, STN);
      end
      finish_test();
   end
endmodule
bind monitor_execute_frame_handler frame_handler_monitor #(.SLOTS(SLOTS)) u_mon (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
   .station_i(station_i), .reg_wr_i(reg_wr_i), .reg_slot_i(reg_slot_i),
   .reg_fmt_i(reg_fmt_i), .reg_blocks_i(reg_blocks_i), .reg_ndata_i(reg_ndata_i),
   .val_req_o(val_req_o), .val_slot_o(val_slot_o), .val_blk_o(val_blk_o),
   .val_idx_o(val_idx_o), .val_ack_i(val_ack_i), .val_data_i(val_data_i),
   .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i));
`default_nettype wire
